// >>> fmed_axis_cmp.sv
// Per-axis magnitude compare against the motion threshold
`timescale 1ns/100ps
module fmed_axis_cmp
    import fmed_pkg::*;
#(
    parameter int SAMPLE_W = 8
) (
    input wire logic [SAMPLE_W-1:0] sample,
    input wire logic [FMED_THR_W-1:0] threshold,
    output logic high,
    output logic neg
);
    initial begin
        if (SAMPLE_W < FMED_MAG_W) begin
            $error("SAMPLE_W below magnitude width");
        end
    end

    logic [SAMPLE_W-1:0] mag;
    logic [FMED_MAG_W-1:0] mag_top;

    // Two's complement magnitude; the most negative code stays exact
    assign mag = sample[SAMPLE_W-1] ? (~sample + 1'b1) : sample;
    assign mag_top = mag[SAMPLE_W-1 -: FMED_MAG_W];
    // Above threshold is motion, at or below is low-g [R17]
    assign high = mag_top > {1'b0, threshold};
    assign neg = sample[SAMPLE_W-1];
endmodule

// >>> fmed_pkg.sv
// Constants for the freefall/motion event detector
package fmed_pkg;
    // Register offsets
    localparam logic [7:0] FMED_ADDR_CFG = 8'h15;
    localparam logic [7:0] FMED_ADDR_SRC = 8'h16;
    localparam logic [7:0] FMED_ADDR_THR = 8'h17;
    localparam logic [7:0] FMED_ADDR_CNT = 8'h18;

    // motion_config fields
    localparam int FMED_CFG_LATCH = 7;
    localparam int FMED_CFG_OR = 6;
    localparam int FMED_CFG_ZEN = 5;
    localparam int FMED_CFG_YEN = 4;
    localparam int FMED_CFG_XEN = 3;
    localparam logic [7:0] FMED_CFG_MASK = 8'hF8;

    // motion_source fields
    localparam int FMED_SRC_EA = 7;

    // motion_threshold fields
    localparam int FMED_THR_MODE = 7;
    localparam int FMED_THR_W = 7;

    // Reset values
    localparam logic [7:0] FMED_CFG_RST = 8'h00;
    localparam logic [7:0] FMED_THR_RST = 8'h00;
    localparam logic [7:0] FMED_CNT_RST = 8'h00;
    localparam logic [5:0] FMED_FLAGS_RST = 6'h00;

    // Magnitude width compared against the threshold
    localparam int FMED_MAG_W = 8;
endpackage

// >>> fmed_testbench.sv
// Self-checking testbench for the freefall/motion event detector
`timescale 1ns/100ps
module testbench;
    import fmed_pkg::*;

    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic sample_valid = 1'b0;
    logic [7:0] x_sample = 8'h00;
    logic [7:0] y_sample = 8'h00;
    logic [7:0] z_sample = 8'h00;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic event_active;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [47:0] row;
    logic [7:0] d;
    // Rows: config, threshold (clear mode), x, y, z, expected source byte
    logic [47:0] rows [10] = '{48'h389005F01080, 48'h389011000002, 48'h789000EF008C,
        48'h489000EF6400, 48'h409000007F00, 48'h009000000000,
        48'h6090000080B0, 48'h509000110088, 48'h509000100000, 48'h2890107FF080};

    fmed_top fmed_top_i (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .sample_valid(sample_valid),
        .x_sample(x_sample),
        .y_sample(y_sample),
        .z_sample(z_sample),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .event_active(event_active)
    );

    always #10 sys_clk = ~sys_clk;

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Hang guard: the whole run needs well under this many cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic do_reset;
        @(negedge sys_clk);
        rst_n = 1'b0;
        repeat (6) @(negedge sys_clk);
        rst_n = 1'b1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask

    // Read data is taken a full cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        @(negedge sys_clk);
        v = reg_rdata;
    endtask

    task automatic smp(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
        @(negedge sys_clk);
        x_sample = x;
        y_sample = y;
        z_sample = z;
        sample_valid = 1'b1;
        @(negedge sys_clk);
        sample_valid = 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic step(input logic [7:0] x, input logic e);
        smp(x, 8'h00, 8'h00);
        chk("event_active", {7'h00, event_active}, {7'h00, e});
    endtask

    task automatic setup(input logic [7:0] cfg, input logic [7:0] thr, input logic [7:0] cnt);
        do_reset();
        wr(FMED_ADDR_CFG, cfg);
        wr(FMED_ADDR_THR, thr);
        wr(FMED_ADDR_CNT, cnt);
    endtask

    initial begin
        do_reset();
        chk("event_active", {7'h00, event_active}, 8'h00);
        rd(FMED_ADDR_CFG, d);
        chk("config", d, FMED_CFG_RST);
        rd(FMED_ADDR_THR, d);
        chk("threshold", d, FMED_THR_RST);
        rd(FMED_ADDR_CNT, d);
        chk("count", d, FMED_CNT_RST);
        wr(FMED_ADDR_THR, 8'h9F);
        rd(FMED_ADDR_THR, d);
        chk("threshold", d, 8'h9F);
        wr(FMED_ADDR_CNT, 8'h05);
        rd(FMED_ADDR_CNT, d);
        chk("count", d, 8'h05);
        rd(FMED_ADDR_SRC, d);
        chk("source", d, 8'h00);
        wr(FMED_ADDR_CFG, 8'hFF);
        rd(FMED_ADDR_CFG, d);
        chk("config", d, 8'hF8);
        wr(FMED_ADDR_SRC, 8'hFF);
        rd(FMED_ADDR_SRC, d);
        chk("source", d, 8'h00);
        rd(8'h30, d);
        chk("unmapped", d, 8'h00);
        do_reset();
        for (int i = 0; i < 10; i++) begin
            row = rows[i];
            wr(FMED_ADDR_CFG, row[47:40]);
            wr(FMED_ADDR_THR, row[39:32]);
            smp(row[31:24], row[23:16], row[15:8]);
            rd(FMED_ADDR_SRC, d);
            chk("source", d, row[7:0]);
            chk("event_active", {7'h00, event_active}, {7'h00, row[7]});
        end
        // Unlatched motion, decrementing debounce of three samples
        setup(8'h48, 8'h10, 8'h03);
        for (int i = 0; i < 6; i++) begin
            step((i < 3) ? 8'h32 : 8'h00, i inside {[2:4]});
            if (i == 3) begin
                rd(FMED_ADDR_SRC, d);
                chk("source", d, 8'h80);
            end
        end
        // Unlatched freefall, clearing debounce of two samples
        setup(8'h38, 8'h90, 8'h02);
        step(8'h00, 1'b0);
        step(8'h00, 1'b1);
        rd(FMED_ADDR_SRC, d);
        chk("event_active", {7'h00, event_active}, 8'h01);
        step(8'h32, 1'b0);
        step(8'h00, 1'b0);
        step(8'h00, 1'b1);
        // Latched motion on x, count of one
        setup(8'hC8, 8'h90, 8'h01);
        step(8'hCE, 1'b1);
        step(8'h32, 1'b1);
        step(8'h00, 1'b1);
        rd(FMED_ADDR_SRC, d);
        chk("source", d, 8'h83);
        chk("event_active", {7'h00, event_active}, 8'h00);
        rd(FMED_ADDR_SRC, d);
        chk("source", d, 8'h00);
        step(8'h32, 1'b1);
        rd(FMED_ADDR_SRC, d);
        chk("source", d, 8'h82);
        // Latched freefall, count of two
        setup(8'hB8, 8'h90, 8'h02);
        step(8'h00, 1'b0);
        step(8'h00, 1'b1);
        step(8'h32, 1'b1);
        rd(FMED_ADDR_SRC, d);
        chk("source", d, 8'h80);
        chk("event_active", {7'h00, event_active}, 8'h00);
        step(8'h00, 1'b0);
        step(8'h00, 1'b1);
        stop_test();
    end
endmodule

// >>> fmed_top.sv
// Freefall/motion event detector with its register file
//
// Function
// (R1) Config bit 6 picks freefall (0, AND) or motion (1, OR).
// (R2) All three axis enables clear disables the detector.
// (R3) Latch enable is config bit 7; event-active is source bit 7.
// (R4) Freefall event-active only after debounce completes, enabled axes only.
// (R5) Unlatched, decrement mode: event-active clears only after count delay.
// (R6) Unlatched freefall, clear mode: flag drops at once, re-arms after delay.
// (R7) Unlatched freefall: source read leaves event-active unchanged.
// (R8) Axis flags track live high-g status when unlatched or event inactive.
// (R9) Latched freefall: flag sets at count, holds until source read.
// (R10) Latched freefall: read clears flag and counter; new event after delay.
// (R11) Latched: axis flags freeze on event, resume after source read.
// (R12) Motion event-active after debounce time, enabled axes only.
// (R13) Unlatched motion, clear mode: flag drops when high-g goes.
// (R14) Unlatched motion: source read clears nothing, counter kept.
// (R15) Latched motion: read clears all source bits and counter.
// (R16) Latched motion: axis flags hold from event until source read.
// (R17) Freefall: all enabled at or below threshold; motion: any above.
// (R18) Polarity 0 positive, 1 negative; both flags zero if axis off.
// (R19) Counter steps once per sample per mode, compared to count value.
`timescale 1ns/100ps
module fmed_top
    import fmed_pkg::*;
#(
    parameter int SAMPLE_W = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sample_valid,
    input wire logic [SAMPLE_W-1:0] x_sample,
    input wire logic [SAMPLE_W-1:0] y_sample,
    input wire logic [SAMPLE_W-1:0] z_sample,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic event_active
);
    initial begin
        if (SAMPLE_W < FMED_MAG_W) begin
            $error("SAMPLE_W below magnitude width");
        end
    end

    logic [7:0] cfg_reg;
    logic [7:0] thr_reg;
    logic [7:0] cnt_val_reg;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic ea_reg;
    logic ea_next;
    logic [5:0] flags_reg;
    logic [5:0] flags_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    // Axis order: index 0 = x, 1 = y, 2 = z
    logic [SAMPLE_W-1:0] axis_sample [3];
    logic [2:0] axis_high;
    logic [2:0] axis_neg;
    logic [2:0] axis_en;
    logic [5:0] live_flags;

    assign axis_sample[0] = x_sample;
    assign axis_sample[1] = y_sample;
    assign axis_sample[2] = z_sample;
    assign axis_en = {cfg_reg[FMED_CFG_ZEN], cfg_reg[FMED_CFG_YEN], cfg_reg[FMED_CFG_XEN]};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_axis
            fmed_axis_cmp #(
                .SAMPLE_W(SAMPLE_W)
            ) u_cmp (
                .sample(axis_sample[gi]),
                .threshold(thr_reg[FMED_THR_W-1:0]),
                .high(axis_high[gi]),
                .neg(axis_neg[gi])
            );
            // High flag above polarity flag, both gated by the enable [R18]
            assign live_flags[2*gi+1] = axis_en[gi] & axis_high[gi];
            assign live_flags[2*gi] = axis_en[gi] & axis_high[gi] & axis_neg[gi];
        end
    endgenerate

    // Decode
    wire latch_on = cfg_reg[FMED_CFG_LATCH]; // [R3]
    wire or_mode = cfg_reg[FMED_CFG_OR]; // [R1]
    wire clear_mode = thr_reg[FMED_THR_MODE];
    wire any_en = |axis_en; // [R2]
    wire any_high = |(axis_en & axis_high);
    wire all_low = ~|(axis_en & axis_high);
    // Freefall is AND of low axes, motion OR of high axes [R1] [R17]
    wire cond = any_en & (or_mode ? any_high : all_low); // [R2] [R4] [R12]
    wire sel_cfg = reg_addr == FMED_ADDR_CFG;
    wire sel_src = reg_addr == FMED_ADDR_SRC;
    wire sel_thr = reg_addr == FMED_ADDR_THR;
    wire sel_cnt = reg_addr == FMED_ADDR_CNT;
    wire src_rd = reg_rd & sel_src;
    // Only latched modes act on a source read [R7] [R14]
    wire src_clear = src_rd & latch_on; // [R10] [R15]
    wire cnt_full = cnt_reg >= cnt_val_reg;
    wire cnt_reached = cnt_next >= cnt_val_reg;

    // Debounce counter, one step per sample [R19]
    always_comb begin
        cnt_next = cnt_reg;
        if (src_clear) begin
            cnt_next = 8'h00; // [R10] [R15]
        end
        if (sample_valid) begin
            if (cond) begin
                cnt_next = cnt_full ? cnt_val_reg : cnt_reg + 8'h01; // [R19]
            end else if (clear_mode) begin
                cnt_next = 8'h00; // [R6] [R13]
            end else if (cnt_reg != 8'h00) begin
                cnt_next = cnt_reg - 8'h01; // [R5]
            end
        end
    end

    // Event-active flag
    always_comb begin
        ea_next = ea_reg;
        if (src_clear) begin
            ea_next = 1'b0; // [R10] [R15]
        end
        if (sample_valid) begin
            if (cond && cnt_reached) begin
                // An event in the read cycle is kept: set beats clear
                ea_next = 1'b1; // [R4] [R9] [R12]
            end else if (!latch_on) begin
                if (clear_mode && !cond) begin
                    ea_next = 1'b0; // [R6] [R13]
                end else if (!clear_mode && cnt_next == 8'h00) begin
                    // Decrement mode holds the flag until count drains [R5]
                    ea_next = 1'b0;
                end
            end
        end
    end

    // Axis flags: live unless latched and the event is active
    always_comb begin
        flags_next = flags_reg;
        if (src_clear) begin
            flags_next = FMED_FLAGS_RST; // [R15]
        end
        if (sample_valid && !(latch_on && ea_reg)) begin
            flags_next = live_flags; // [R8] [R11] [R16]
        end
    end

    // Register read data, sampled before any clear of the same cycle
    always_comb begin
        rdata_next = 8'h00;
        if (sel_cfg) begin
            rdata_next = cfg_reg & FMED_CFG_MASK;
        end else if (sel_src) begin
            rdata_next = {ea_reg, 1'b0, flags_reg}; // [R3]
        end else if (sel_thr) begin
            rdata_next = thr_reg;
        end else if (sel_cnt) begin
            rdata_next = cnt_val_reg;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg <= FMED_CFG_RST;
            thr_reg <= FMED_THR_RST;
            cnt_val_reg <= FMED_CNT_RST;
        end else if (reg_wr) begin
            if (sel_cfg) begin
                cfg_reg <= reg_wdata & FMED_CFG_MASK;
            end
            if (sel_thr) begin
                thr_reg <= reg_wdata;
            end
            if (sel_cnt) begin
                cnt_val_reg <= reg_wdata;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 8'h00;
            ea_reg <= 1'b0;
            flags_reg <= FMED_FLAGS_RST;
        end else begin
            cnt_reg <= cnt_next;
            ea_reg <= ea_next;
            flags_reg <= flags_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
            event_active <= 1'b0;
        end else begin
            event_active <= ea_next;
            if (reg_rd) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign reg_rdata = rdata_reg;

    // Checks
    property p_disabled;
        @(posedge sys_clk) disable iff (!rst_n)
        (axis_en == 3'h0) |-> !cond;
    endproperty
    a_disabled: assert property (p_disabled) else $error("detector active with no axis"); // [R2]

    property p_motion_or;
        @(posedge sys_clk) disable iff (!rst_n)
        (or_mode && |(axis_en & axis_high)) |-> cond;
    endproperty
    a_motion_or: assert property (p_motion_or) else $error("motion missed high axis"); // [R17]

    property p_ff_and;
        @(posedge sys_clk) disable iff (!rst_n)
        (!or_mode && |(axis_en & axis_high)) |-> !cond;
    endproperty
    a_ff_and: assert property (p_ff_and) else $error("freefall with high axis"); // [R1]

    property p_unlatched_read;
        @(posedge sys_clk) disable iff (!rst_n)
        (src_rd && !latch_on && !sample_valid && !reg_wr)
            |=> (ea_reg == $past(ea_reg)) && (cnt_reg == $past(cnt_reg));
    endproperty
    a_unlatched_read: assert property (p_unlatched_read) else $error("read changed state"); // [R7]

    property p_latched_read;
        @(posedge sys_clk) disable iff (!rst_n)
        (src_rd && latch_on && !sample_valid)
            |=> !ea_reg && cnt_reg == 8'h00 && flags_reg == 6'h00;
    endproperty
    a_latched_read: assert property (p_latched_read) else $error("latched read kept state"); // [R15]

    property p_freeze;
        @(posedge sys_clk) disable iff (!rst_n)
        (latch_on && ea_reg && !src_rd && !reg_wr) |=> $stable(flags_reg);
    endproperty
    a_freeze: assert property (p_freeze) else $error("latched flags moved"); // [R11]

    property p_clear_mode;
        @(posedge sys_clk) disable iff (!rst_n)
        (sample_valid && !latch_on && clear_mode && !cond) |=> !ea_reg && cnt_reg == 8'h00;
    endproperty
    a_clear_mode: assert property (p_clear_mode) else $error("flag held in clear mode"); // [R6]

    property p_decrement_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        (!latch_on && !clear_mode && ea_reg && cnt_reg > 8'h01 && !reg_wr) |=> ea_reg;
    endproperty
    a_decrement_hold: assert property (p_decrement_hold) else $error("flag dropped early"); // [R5]

    property p_count_step;
        @(posedge sys_clk) disable iff (!rst_n)
        (sample_valid && cond && cnt_reg < cnt_val_reg && !src_clear && !reg_wr)
            |=> cnt_reg == $past(cnt_reg) + 8'h01;
    endproperty
    a_count_step: assert property (p_count_step) else $error("counter did not step"); // [R19]

    property p_live_flags;
        @(posedge sys_clk) disable iff (!rst_n)
        (sample_valid && !latch_on) |=> flags_reg == $past(live_flags);
    endproperty
    a_live_flags: assert property (p_live_flags) else $error("flags not live"); // [R8]

    property p_set_at_count;
        @(posedge sys_clk) disable iff (!rst_n)
        (sample_valid && cond && cnt_full) |=> ea_reg && event_active;
    endproperty
    a_set_at_count: assert property (p_set_at_count) else $error("event not raised"); // [R9]

    property p_early;
        @(posedge sys_clk) disable iff (!rst_n)
        (!ea_reg && !(sample_valid && cond && cnt_reached)) |=> !ea_reg;
    endproperty
    a_early: assert property (p_early) else $error("event raised before count"); // [R4]
endmodule
